// >>> hw/rcl_pkg.sv
/*
  Shared constants and state types for the reset sequencing and
  configuration latch block.
  Assumes one reference clock and a synchronous active-low logic reset.
*/
`default_nettype none

package rcl_pkg;

  // configuration word width; the word layout is decoded elsewhere
  localparam int CFG_W = 16;

  // synchroniser lanes: three reset pins then the configuration word
  localparam int SYN_POR = 0;
  localparam int SYN_HRD = 1;
  localparam int SYN_SRT = 2;
  localparam int SYN_CFG = 3;
  localparam int SYN_W = SYN_CFG + CFG_W;

  // reset request minimum width and stretch length, in reference cycles
  localparam logic [2:0] MIN_W = 3'h4;
  localparam logic [12:0] STRETCH = 13'h1000;

  typedef struct packed {
    logic [SYN_W-1:0] ff1;
    logic [SYN_W-1:0] ff2;
  } rcl_sync_s;

  // reset lanes read as asserted and the word lanes as zero until real samples arrive
  localparam rcl_sync_s RCL_SYNC_RST = '0;

  typedef struct packed {
    logic por_seen;
    logic por_valid;
    logic [2:0] por_wcnt;
    logic [2:0] hrd_wcnt;
    logic [2:0] srt_wcnt;
    logic [12:0] pin_cnt;
    logic [12:0] int_cnt;
    logic [2:0] drv_hist;
    logic int_hrst;
    logic int_srst;
    logic [CFG_W-1:0] cfg;
  } rcl_state_s;

  localparam rcl_state_s RCL_ST_RST = '0;

endpackage

`default_nettype wire

// >>> hw/rcl_sync_if.sv
/*
  Carrier between the sequencer and its pin synchroniser.
  Assumes both ends sit on the same reference clock.
*/
`default_nettype none

interface rcl_sync_if;
  import rcl_pkg::*;
  logic [SYN_W-1:0] raw;
  logic [SYN_W-1:0] sync;
  modport src (output raw, input sync);
  modport syn (input raw, output sync);
endinterface

`default_nettype wire

// >>> hw/rcl_sync.sv
/*
  Two-flop synchroniser for the reset pins and configuration word pins.
  Assumes pins are asynchronous to clk; rst_b is synchronous active low.
*/
`default_nettype none

module rcl_sync
  import rcl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pin lanes
  rcl_sync_if.syn sif
);

  rcl_sync_s st;
  rcl_sync_s next_st;

  // first stage feeds only the second stage
  always_comb
  begin
    next_st = st;
    next_st.ff1 = sif.raw;
    next_st.ff2 = st.ff1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      st <= RCL_SYNC_RST;
    else
      st <= next_st;
  end

  assign sif.sync = st.ff2;

  property p_sync_depth;
    @(posedge clk) disable iff (!rst_b)
      $past(rst_b, 2) |-> (sif.sync == $past(sif.raw, 2));
  endproperty
  a_sync_depth: assert property (p_sync_depth)
    else $error("synchroniser output is not the pin value two cycles back");

endmodule // rcl_sync

`default_nettype wire

// >>> hw/rcl_top.sv
/*
  Reset sequencer and configuration word latch: accepts power-on, hard and
  soft reset pins, stretches pin and internal resets, and freezes the
  configuration word when reset ends.
  Assumes the reference clock on clk and open-drain reset pins resolved
  outside; rst_b is a synchronous active-low logic reset.
*/
// Summary of operation
// - three active-low open-drain reset pins, async; requests need four cycles low, except the first power-on after logic reset
// - after power-on release, hard and soft pins stay low 4096 cycles
// - valid hard request release stretches internal resets 4096 cycles
// - later power-on pulses need only the four-cycle minimum width
// - config word sampled every edge while hard or power-on reset active
// - config word frozen once both hard and power-on resets are high
// - hard pin driven low by power-on reset without any clock
`default_nettype none

module rcl_top
  import rcl_pkg::*;
(
  // clock and logic reset
  input wire logic clk,
  input wire logic rst_b,
  // power-on reset pin
  input wire logic power_on_reset_n_in,
  output logic power_on_reset_n_out,
  output logic power_on_reset_n_oe,
  // hard reset pin
  input wire logic hard_reset_n_in,
  output logic hard_reset_n_out,
  output logic hard_reset_n_oe,
  // soft reset pin
  input wire logic soft_reset_n_in,
  output logic soft_reset_n_out,
  output logic soft_reset_n_oe,
  // configuration word pins and latched word
  input wire logic [CFG_W-1:0] cfg_pins,
  output logic [CFG_W-1:0] cfg_word,
  // internal resets
  output logic int_hard_reset_n,
  output logic int_soft_reset_n
);

  rcl_sync_if sif ();

  rcl_state_s st;
  rcl_state_s next_st;
  logic por_low;
  logic hrd_low;
  logic srt_low;
  logic own_drv;
  logic ext_h;
  logic ext_s;
  logic por_rel;
  logic hrd_rel;
  logic pin_hold;

  assign sif.raw = {cfg_pins, soft_reset_n_in, hard_reset_n_in, power_on_reset_n_in};

  rcl_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .sif(sif)
  );

  always_comb
  begin
    next_st = st;
    por_low = ~sif.sync[SYN_POR];
    hrd_low = ~sif.sync[SYN_HRD];
    srt_low = ~sif.sync[SYN_SRT];
    // our own pin drive echoes back through the synchroniser for a while
    own_drv = st.por_valid | (st.pin_cnt != 13'h0000) | (st.drv_hist != 3'h0);
    // a refused power-on pulse also drives the pins, so its echo is masked too
    next_st.drv_hist = {st.drv_hist[1:0], por_low | st.por_valid | (st.pin_cnt != 13'h0000)};
    ext_h = hrd_low & ~por_low & ~own_drv;
    ext_s = srt_low & ~por_low & ~own_drv;

    // power-on width: first one after logic reset is taken at once
    if (por_low)
    begin
      next_st.por_wcnt = (st.por_wcnt == MIN_W) ? MIN_W : st.por_wcnt + 3'h1;
    end
    else
    begin
      next_st.por_wcnt = 3'h0;
    end
    if (por_low && (!st.por_seen || next_st.por_wcnt == MIN_W))
    begin
      next_st.por_valid = 1'b1;
    end
    por_rel = st.por_valid & ~por_low;

    // hard and soft request widths, ignored while we drive the pins
    if (ext_h)
    begin
      next_st.hrd_wcnt = (st.hrd_wcnt == MIN_W) ? MIN_W : st.hrd_wcnt + 3'h1;
    end
    else
    begin
      next_st.hrd_wcnt = 3'h0;
    end
    if (ext_s)
    begin
      next_st.srt_wcnt = (st.srt_wcnt == MIN_W) ? MIN_W : st.srt_wcnt + 3'h1;
    end
    else
    begin
      next_st.srt_wcnt = 3'h0;
    end
    hrd_rel = (st.hrd_wcnt == MIN_W) & ~hrd_low;

    // pin stretch after power-on release
    if (por_rel)
    begin
      next_st.por_valid = 1'b0;
      next_st.por_seen = 1'b1;
      next_st.pin_cnt = STRETCH;
    end
    else if (st.pin_cnt != 13'h0000)
    begin
      next_st.pin_cnt = st.pin_cnt - 13'h0001;
    end

    // internal stretch after power-on or valid hard release
    if (por_rel || hrd_rel)
    begin
      next_st.int_cnt = STRETCH;
    end
    else if (st.int_cnt != 13'h0000)
    begin
      next_st.int_cnt = st.int_cnt - 13'h0001;
    end

    next_st.int_hrst = next_st.por_valid | (next_st.int_cnt != 13'h0000) | (next_st.hrd_wcnt == MIN_W);
    next_st.int_srst = next_st.int_hrst | (next_st.srt_wcnt == MIN_W);

    // the word keeps the last synchronised value once both resets are high
    if (por_low || hrd_low)
    begin
      next_st.cfg = sif.sync[SYN_CFG +: CFG_W];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      st <= RCL_ST_RST;
    else
      st <= next_st;
  end

  // raw power-on pin gates the hard drive directly so no clock is needed;
  // a glitch on it reaches the pin unfiltered
  // synchronised low bridges the cycles between a raw release and por_valid,
  // so an accepted pulse never lets the pins blink high
  assign pin_hold = ~sif.sync[SYN_POR] | st.por_valid | (st.pin_cnt != 13'h0000);
  assign hard_reset_n_oe = ~power_on_reset_n_in | pin_hold;
  assign soft_reset_n_oe = ~power_on_reset_n_in | pin_hold;
  assign hard_reset_n_out = 1'b0;
  assign soft_reset_n_out = 1'b0;
  // power-on pin is never driven by this end
  assign power_on_reset_n_out = 1'b0;
  assign power_on_reset_n_oe = 1'b0;
  assign cfg_word = st.cfg;
  assign int_hard_reset_n = ~st.int_hrst;
  assign int_soft_reset_n = ~st.int_srst;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_hreq;
    ext_h [*4];
  endsequence

  // accepted power-on seen released through the synchroniser
  sequence s_por_rel;
    st.por_valid && sif.sync[SYN_POR];
  endsequence

  property p_hreq_width;
    s_hreq |=> !int_hard_reset_n;
  endproperty
  a_hreq_width: assert property (p_hreq_width)
    else $error("four-cycle hard request did not assert internal reset");

  property p_pin_stretch;
    s_por_rel |=> (st.pin_cnt == STRETCH) ##1 (hard_reset_n_oe && soft_reset_n_oe && st.pin_cnt == 13'h0FFF);
  endproperty
  a_pin_stretch: assert property (p_pin_stretch)
    else $error("pin stretch did not start after power-on release");

  property p_pin_hold;
    (st.pin_cnt != 13'h0000) |-> (hard_reset_n_oe && soft_reset_n_oe);
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("reset pins released during stretch");

  property p_int_stretch;
    (hrd_rel && !por_rel) |=> (st.int_cnt == STRETCH) && !int_hard_reset_n;
  endproperty
  a_int_stretch: assert property (p_int_stretch)
    else $error("hard release did not reload internal stretch");

  property p_int_count;
    (st.int_cnt != 13'h0000 && !por_rel && !hrd_rel) |=>
      (st.int_cnt == $past(st.int_cnt) - 13'h0001) && (!int_hard_reset_n || st.int_cnt == 13'h0000);
  endproperty
  a_int_count: assert property (p_int_count)
    else $error("internal stretch counter did not step down by one");

  property p_por_width;
    (st.por_seen && !st.por_valid && por_low && st.por_wcnt == 3'h3) |=> st.por_valid;
  endproperty
  a_por_width: assert property (p_por_width)
    else $error("power-on pulse of four cycles not accepted");

  property p_por_short;
    (st.por_seen && !st.por_valid && !por_low) |=> !st.por_valid;
  endproperty
  a_por_short: assert property (p_por_short)
    else $error("power-on accepted without being low");

  property p_cfg_track;
    (por_low || hrd_low) |=> (cfg_word == $past(sif.sync[SYN_CFG +: CFG_W]));
  endproperty
  a_cfg_track: assert property (p_cfg_track)
    else $error("config word not sampled during reset");

  property p_cfg_lock;
    (!por_low && !hrd_low) |=> $stable(cfg_word);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock)
    else $error("config word changed after reset ended");

  property p_por_drive;
    !power_on_reset_n_in |-> hard_reset_n_oe;
  endproperty
  a_por_drive: assert property (p_por_drive)
    else $error("hard pin not driven while power-on reset low");

  property p_rel_sync;
    $rose(st.pin_cnt == STRETCH) |-> $past(sif.sync[SYN_POR]);
  endproperty
  a_rel_sync: assert property (p_rel_sync)
    else $error("stretch started before synchronised release");

endmodule // rcl_top

`default_nettype wire

// >>> verification/rcl_board.sv
/*
  Board side model: reset supervisor and configuration strapping.
  Assumes device oe high drives its out level; hard and soft pins have pull-ups.
*/
`default_nettype none

module rcl_board
  import rcl_pkg::*;
(
  // clock
  input wire logic clk,
  // bench requests, active high
  input wire logic por_req,
  input wire logic hrd_req,
  input wire logic srt_req,
  input wire logic [CFG_W-1:0] cfg_req,
  // device pin drives
  input wire logic hrd_oe,
  input wire logic hrd_out,
  input wire logic srt_oe,
  input wire logic srt_out,
  // resolved pins
  output logic por_pin,
  output logic hrd_pin,
  output logic srt_pin,
  output logic [CFG_W-1:0] cfg_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // registered so the power-on pin cannot glitch
  always_ff @(posedge clk)
  begin
    por_pin <= ~por_req;
  end

  // open drain with pull-up: low if the board pulls or the device drives low
  assign hrd_pin = ~hrd_req & (~hrd_oe | hrd_out);
  assign srt_pin = ~srt_req & (~srt_oe | srt_out);
  // strapping only moves when a scenario asks
  assign cfg_pins = cfg_req;
endmodule // rcl_board

`default_nettype wire

// >>> verification/rcl_top_tb.sv
/*
  Self-checking bench for the reset sequencer and configuration latch.
  Assumes rcl_board resolves the pins; clk runs at 100 MHz.
*/
`default_nettype none

module rcl_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rcl_pkg::*;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_req = 1'b1;
  logic hrd_req = 1'b0;
  logic srt_req = 1'b0;
  logic [CFG_W-1:0] cfg_req = 16'hA5C3;
  wire logic por_pin, hrd_pin, srt_pin, hrd_oe, srt_oe, ih_n, is_n, pr_oe, hrd_o, srt_o;
  wire logic [CFG_W-1:0] cfg_pins, cfg_word;
  int miscompares = 0;
  int n_checks = 0;
  int n;
  int m;

  always #5 clk = ~clk;

  rcl_board rcl_board_inst (.clk(clk), .por_req(por_req), .hrd_req(hrd_req),
    .srt_req(srt_req), .cfg_req(cfg_req), .hrd_oe(hrd_oe), .hrd_out(hrd_o), .srt_oe(srt_oe), .srt_out(srt_o),
    .por_pin(por_pin), .hrd_pin(hrd_pin), .srt_pin(srt_pin), .cfg_pins(cfg_pins));

  rcl_top rcl_top_inst (.clk(clk), .rst_b(rst_b),
    .power_on_reset_n_in(por_pin), .power_on_reset_n_out(), .power_on_reset_n_oe(pr_oe),
    .hard_reset_n_in(hrd_pin), .hard_reset_n_out(hrd_o), .hard_reset_n_oe(hrd_oe),
    .soft_reset_n_in(srt_pin), .soft_reset_n_out(srt_o), .soft_reset_n_oe(srt_oe),
    .cfg_pins(cfg_pins), .cfg_word(cfg_word), .int_hard_reset_n(ih_n), .int_soft_reset_n(is_n));

  task print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task rng(input string nm, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi)
    begin
      miscompares++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, got);
    end
  endtask

  function logic pick(input int k);
    return k == 0 ? hrd_pin : ih_n;
  endfunction

  // bounded wait for a level; a hang ends the run
  task wait_lvl(input int k, input logic v, output int cnt);
    cnt = 0;
    while (pick(k) !== v)
    begin
      @(posedge clk);
      #1;
      cnt++;
      if (cnt > 6000)
      begin
        miscompares++;
        print_verdict();
      end
    end
  endtask

  task pulse(input int k, input int cyc);
    @(posedge clk);
    case (k)
      0: por_req <= 1'b1;
      1: hrd_req <= 1'b1;
      default: srt_req <= 1'b1;
    endcase
    repeat (cyc) @(posedge clk);
    case (k)
      0: por_req <= 1'b0;
      1: hrd_req <= 1'b0;
      default: srt_req <= 1'b0;
    endcase
  endtask

  task s_por_first;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("hard_oe", 16'h1, {15'h0, hrd_oe});
    chk("soft_oe", 16'h1, {15'h0, srt_oe});
    repeat (4) @(posedge clk);
    cfg_req <= 16'h1234;
    repeat (6) @(posedge clk);
    #1;
    chk("cfg_word", 16'h1234, cfg_word);
    chk("int_hard", 16'h0, {15'h0, ih_n});
    @(posedge clk);
    por_req <= 1'b0;
    wait_lvl(0, 1'b1, n);
    rng("hard_pin_low", 4096, 4104, n);
    chk("soft_pin", 16'h1, {15'h0, srt_pin});
    repeat (4) @(posedge clk);
    cfg_req <= 16'hFFFF;
    repeat (6) @(posedge clk);
    #1;
    chk("cfg_frozen", 16'h1234, cfg_word);
  endtask

  task s_hard;
    repeat (10) @(posedge clk);
    pulse(1, 4);
    wait_lvl(1, 1'b0, n);
    wait_lvl(1, 1'b1, m);
    rng("int_hard_low", 4096, 4106, n + m);
    pulse(1, 3);
    m = 0;
    repeat (12)
    begin
      @(posedge clk);
      #1;
      if (ih_n !== 1'b1)
        m++;
    end
    rng("short_hard", 0, 0, m);
  endtask

  task s_soft;
    pulse(2, 8);
    #1;
    chk("int_soft", 16'h0, {15'h0, is_n});
    chk("int_hard", 16'h1, {15'h0, ih_n});
    repeat (6) @(posedge clk);
    #1;
    chk("soft_end", 16'h1, {15'h0, is_n});
  endtask

  task s_por_late;
    repeat (10) @(posedge clk);
    pulse(0, 4);
    wait_lvl(0, 1'b1, n);
    rng("late_por", 4096, 4106, n);
    chk("por_oe", 16'h0, {15'h0, pr_oe});
    repeat (10) @(posedge clk);
    pulse(0, 3);
    wait_lvl(0, 1'b1, n);
    rng("short_por", 0, 6, n);
  endtask

  initial
  begin
    s_por_first();
    s_hard();
    s_soft();
    s_por_late();
    print_verdict();
  end
endmodule // rcl_top_tb

`default_nettype wire
